// *** sfcrf_regs.vh ***
// Operation
// - All bytes move MSB first
// - Unknown opcode: ignore input until reselect
// - Early deselect before address: do nothing
// - Three address bytes, top bit ignored
// - Read dummies: 1Bh two, 0Bh one, 03h none
// - Data streams out, address auto-increments
// - Address wraps 7FFFFFh to 000000h, no gap
// - Deselect ends read, output tristated at once
// - Block erases take three address bytes only
// - Page program: address then data bytes
// - Dual-input program: address then data bytes
// - Protection readback: address then read data
// - OTP read: address, two dummies, data
// - Lockdown and freeze: address, one byte
// - Lockdown readback: address then read data
// - Status writes one byte; status read streams
// - ID read returns one to four bytes
// - Power-down enter/exit are opcode only
// - Sample on rising, change on falling edge
// - Pause input freezes link, tristates output
`ifndef SFCRF_REGS_VH
`define SFCRF_REGS_VH

// ****************************************************************
// Opcodes
// ****************************************************************
`define SFCRF_OP_RD_TWO_DUMMY   8'h1B
`define SFCRF_OP_RD_ONE_DUMMY   8'h0B
`define SFCRF_OP_RD_NO_DUMMY    8'h03
`define SFCRF_OP_RD_DUAL        8'h3B
`define SFCRF_OP_ERASE_4K       8'h20
`define SFCRF_OP_ERASE_32K      8'h52
`define SFCRF_OP_ERASE_64K      8'hD8
`define SFCRF_OP_ERASE_CHIP_A   8'h60
`define SFCRF_OP_ERASE_CHIP_B   8'hC7
`define SFCRF_OP_PROGRAM        8'h02
`define SFCRF_OP_PROGRAM_DUAL   8'hA2
`define SFCRF_OP_SUSPEND        8'hB0
`define SFCRF_OP_RESUME         8'hD0
`define SFCRF_OP_WR_ENABLE      8'h06
`define SFCRF_OP_WR_DISABLE     8'h04
`define SFCRF_OP_PROTECT        8'h36
`define SFCRF_OP_UNPROTECT      8'h39
`define SFCRF_OP_RD_PROTECT     8'h3C
`define SFCRF_OP_LOCKDOWN       8'h33
`define SFCRF_OP_LOCK_FREEZE    8'h34
`define SFCRF_OP_RD_LOCKDOWN    8'h35
`define SFCRF_OP_OTP_PROGRAM    8'h9B
`define SFCRF_OP_OTP_READ       8'h77
`define SFCRF_OP_RD_STATUS      8'h05
`define SFCRF_OP_WR_STATUS1     8'h01
`define SFCRF_OP_WR_STATUS2     8'h31
`define SFCRF_OP_RESET          8'hF0
`define SFCRF_OP_RD_ID          8'h9F
`define SFCRF_OP_DEEP_DOWN      8'hB9
`define SFCRF_OP_DEEP_UP        8'hAB

// ****************************************************************
// Framing fields
// ****************************************************************
`define SFCRF_KIND_NONE         2'h0
`define SFCRF_KIND_IN           2'h1
`define SFCRF_KIND_OUT          2'h2
`define SFCRF_ADDR_LAST_BYTE    2'h2
`define SFCRF_ID_MAX_BYTES      3'h4
`define SFCRF_ADDR_WIDTH        23

// ****************************************************************
// States, one-hot
// ****************************************************************
`define SFCRF_ST_IDLE           7'h01
`define SFCRF_ST_OPCODE         7'h02
`define SFCRF_ST_ADDR           7'h04
`define SFCRF_ST_DUMMY          7'h08
`define SFCRF_ST_DATAIN         7'h10
`define SFCRF_ST_DATAOUT        7'h20
`define SFCRF_ST_IGNORE         7'h40

`endif

// *** sfcrf_buf2.v ***
`timescale 1ns/10ps
`include "sfcrf_regs.vh"

// ****************************************************************
// Two-entry buffer
// ****************************************************************
module sfcrf_buf2
#(
  parameter WIDTH = 8
)
(
  input  wire             clk,
  input  wire             nrst,
  input  wire             flush,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData,
  output wire [1:0]       count
);

  reg [WIDTH-1:0] entry0;
  reg [WIDTH-1:0] entry1;
  reg [1:0]       fill;
  wire            push;
  wire            pop;

  assign inReady  = (fill != 2'h2);
  assign outValid = (fill != 2'h0);
  assign outData  = entry0;
  assign count    = fill;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fill   <= 2'h0;
      entry0 <= {WIDTH{1'b0}};
      entry1 <= {WIDTH{1'b0}};
    end
    else if (flush)
    begin
      fill <= 2'h0;
    end
    else
    begin
      if (pop)
      begin
        entry0 <= (fill == 2'h2) ? entry1 : inData;
      end
      else if (push && fill == 2'h0)
      begin
        entry0 <= inData;
      end
      if (push && ((fill == 2'h1 && !pop) || fill == 2'h2))
      begin
        entry1 <= inData;
      end
      if (push && !pop)
      begin
        fill <= fill + 2'h1;
      end
      else if (pop && !push)
      begin
        fill <= fill - 2'h1;
      end
    end
  end

endmodule

// *** sfcrf_front.v ***
`timescale 1ns/10ps
`include "sfcrf_regs.vh"

// ****************************************************************
// Serial flash command and read front end
// ****************************************************************
module sfcrf_front
#(
  parameter ADDR_WIDTH = `SFCRF_ADDR_WIDTH
)
(
  input  wire                  clk,
  input  wire                  nrst,
  input  wire                  csN,
  input  wire                  sck,
  input  wire                  si,
  input  wire                  holdN,
  output reg                   so,
  output wire                  soOe,
  output reg                   cmdValid,
  output reg  [7:0]            cmdOpcode,
  output reg  [ADDR_WIDTH-1:0] cmdAddr,
  output reg                   rxValid,
  output reg  [7:0]            rxByte,
  output reg                   cmdEnd,
  output reg                   cmdDone,
  output wire                  fetchValid,
  input  wire                  fetchReady,
  output reg  [ADDR_WIDTH-1:0] fetchAddr,
  input  wire                  rdValid,
  output wire                  rdReady,
  input  wire [7:0]            rdData
);

  // ****************************************************************
  // Opcode table: {known, hasAddr, dummy[1:0], kind[1:0], exactOne}
  // ****************************************************************
  function [6:0] decode;
    input [7:0] op;
    begin
      case (op)
        `SFCRF_OP_RD_TWO_DUMMY : decode = {1'b1, 1'b1, 2'h2, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_RD_ONE_DUMMY : decode = {1'b1, 1'b1, 2'h1, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_RD_NO_DUMMY  : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_RD_DUAL      : decode = {1'b1, 1'b1, 2'h1, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_ERASE_4K,
        `SFCRF_OP_ERASE_32K,
        `SFCRF_OP_ERASE_64K    : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_NONE, 1'b0};
        `SFCRF_OP_ERASE_CHIP_A,
        `SFCRF_OP_ERASE_CHIP_B : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_NONE, 1'b0};
        `SFCRF_OP_PROGRAM      : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_IN, 1'b0};
        `SFCRF_OP_PROGRAM_DUAL : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_IN, 1'b0};
        `SFCRF_OP_RD_PROTECT   : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_OTP_READ     : decode = {1'b1, 1'b1, 2'h2, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_LOCKDOWN,
        `SFCRF_OP_LOCK_FREEZE  : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_IN, 1'b1};
        `SFCRF_OP_RD_LOCKDOWN  : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_WR_STATUS1,
        `SFCRF_OP_WR_STATUS2   : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_IN, 1'b1};
        `SFCRF_OP_RD_STATUS    : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_RD_ID        : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_OUT, 1'b0};
        `SFCRF_OP_DEEP_DOWN,
        `SFCRF_OP_DEEP_UP      : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_NONE, 1'b0};
        `SFCRF_OP_WR_ENABLE,
        `SFCRF_OP_WR_DISABLE,
        `SFCRF_OP_SUSPEND,
        `SFCRF_OP_RESUME       : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_NONE, 1'b0};
        `SFCRF_OP_PROTECT,
        `SFCRF_OP_UNPROTECT    : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_NONE, 1'b0};
        `SFCRF_OP_OTP_PROGRAM  : decode = {1'b1, 1'b1, 2'h0, `SFCRF_KIND_IN, 1'b0};
        `SFCRF_OP_RESET        : decode = {1'b1, 1'b0, 2'h0, `SFCRF_KIND_IN, 1'b1};
        default                : decode = 7'h00;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [1:0] csSync;
  reg [1:0] sckSync;
  reg [1:0] siSync;
  reg [1:0] holdSync;
  reg       sckPrev;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      csSync   <= 2'h3;
      sckSync  <= 2'h0;
      siSync   <= 2'h0;
      holdSync <= 2'h3;
      sckPrev  <= 1'b0;
    end
    else
    begin
      csSync   <= {csSync[0], csN};
      sckSync  <= {sckSync[0], sck};
      siSync   <= {siSync[0], si};
      holdSync <= {holdSync[0], holdN};
      sckPrev  <= sckSync[1];
    end
  end

  wire csActive = ~csSync[1];
  wire sckLevel = sckSync[1];
  wire siLevel  = siSync[1];
  wire holdLow  = ~holdSync[1];

  // ****************************************************************
  // Pause handling
  // ****************************************************************
  reg holdActive;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      holdActive <= 1'b0;
    end
    else if (!csActive || !holdLow)
    begin
      holdActive <= 1'b0;
    end
    else if (!sckLevel)
    begin
      holdActive <= 1'b1;
    end
  end

  // Edges frozen while paused
  wire sckRise = csActive & ~holdActive & sckLevel & ~sckPrev;
  wire sckFall = csActive & ~holdActive & ~sckLevel & sckPrev;

  // ****************************************************************
  // Receive shifter
  // ****************************************************************
  reg  [6:0] state;
  reg  [2:0] bitCnt;
  reg  [6:0] rxShift;
  reg  [1:0] byteCnt;
  reg  [15:0] addrHigh;
  reg  [1:0] dummyNeed;
  reg  [1:0] dataKind;
  reg        exactOne;
  reg        frameOk;
  reg        isIdRead;
  wire [7:0] fullByte = {rxShift, siLevel};
  wire       byteDone = sckRise & (bitCnt == 3'h7);
  wire [6:0] dec      = decode(fullByte);

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  reg        outStarted;
  reg  [2:0] outBit;
  reg  [6:0] outShift;
  reg  [2:0] outBytes;
  reg  [1:0] pending;
  wire [1:0] bufCount;
  wire       bufValid;
  wire [7:0] bufData;
  wire       bufInReady;
  wire       inDataOut = (state == `SFCRF_ST_DATAOUT);
  wire       loadByte  = inDataOut & sckFall & (outBit == 3'h0);
  wire       idLimit   = isIdRead & (outBytes == `SFCRF_ID_MAX_BYTES);
  wire       fetchGo   = fetchValid & fetchReady;
  wire       rdTake    = rdValid & rdReady;

  // Credit keeps fetches within the buffer's free space; none before start address loads
  assign fetchValid = inDataOut & ~cmdValid & ~idLimit & (({1'b0, bufCount} + {1'b0, pending}) < 3'h2);
  assign rdReady    = inDataOut & bufInReady;
  assign soOe       = inDataOut & outStarted & ~holdActive;

  sfcrf_buf2
  #(
    .WIDTH (8)
  )
  u_buf
  (
    .clk      (clk),
    .nrst     (nrst),
    .flush    (~inDataOut),
    .inValid  (rdValid & inDataOut),
    .inReady  (bufInReady),
    .inData   (rdData),
    .outValid (bufValid),
    .outReady (loadByte),
    .outData  (bufData),
    .count    (bufCount)
  );

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state     <= `SFCRF_ST_IDLE;
      bitCnt    <= 3'h0;
      rxShift   <= 7'h00;
      byteCnt   <= 2'h0;
      addrHigh  <= 16'h0000;
      dummyNeed <= 2'h0;
      dataKind  <= `SFCRF_KIND_NONE;
      exactOne  <= 1'b0;
      frameOk   <= 1'b0;
      isIdRead  <= 1'b0;
      cmdValid  <= 1'b0;
      cmdOpcode <= 8'h00;
      cmdAddr   <= {ADDR_WIDTH{1'b0}};
      rxValid   <= 1'b0;
      rxByte    <= 8'h00;
      cmdEnd    <= 1'b0;
      cmdDone   <= 1'b0;
    end
    else
    begin
      cmdValid <= 1'b0;
      rxValid  <= 1'b0;
      cmdEnd   <= 1'b0;
      if (!csActive)
      begin
        // Deselect ends any frame; early ends report no completion
        if (state != `SFCRF_ST_IDLE)
        begin
          cmdEnd  <= 1'b1;
          cmdDone <= frameOk & (bitCnt == 3'h0);
        end
        state   <= `SFCRF_ST_IDLE;
        bitCnt  <= 3'h0;
        frameOk <= 1'b0;
      end
      else
      begin
        if (sckRise)
        begin
          bitCnt  <= bitCnt + 3'h1;
          rxShift <= fullByte[6:0];
        end
        case (state)
          `SFCRF_ST_IDLE:
          begin
            state    <= `SFCRF_ST_OPCODE;
            isIdRead <= 1'b0;
          end
          `SFCRF_ST_OPCODE:
          begin
            if (byteDone)
            begin
              cmdOpcode <= fullByte;
              dummyNeed <= dec[4:3];
              dataKind  <= dec[2:1];
              exactOne  <= dec[0];
              byteCnt   <= 2'h0;
              isIdRead  <= (fullByte == `SFCRF_OP_RD_ID);
              if (!dec[6])
              begin
                state <= `SFCRF_ST_IGNORE;
              end
              else if (dec[5])
              begin
                state <= `SFCRF_ST_ADDR;
              end
              else
              begin
                cmdValid <= 1'b1;
                frameOk  <= 1'b1;
                cmdAddr  <= {ADDR_WIDTH{1'b0}};
                case (dec[2:1])
                  `SFCRF_KIND_IN  : state <= `SFCRF_ST_DATAIN;
                  `SFCRF_KIND_OUT : state <= `SFCRF_ST_DATAOUT;
                  default         : state <= `SFCRF_ST_IGNORE;
                endcase
              end
            end
          end
          `SFCRF_ST_ADDR:
          begin
            if (byteDone)
            begin
              addrHigh <= {addrHigh[7:0], fullByte};
              byteCnt  <= byteCnt + 2'h1;
              if (byteCnt == `SFCRF_ADDR_LAST_BYTE)
              begin
                // Top address bit dropped by the width of cmdAddr
                cmdAddr  <= {addrHigh[ADDR_WIDTH-9:0], fullByte};
                cmdValid <= 1'b1;
                frameOk  <= 1'b1;
                byteCnt  <= 2'h0;
                if (dummyNeed != 2'h0)
                begin
                  state <= `SFCRF_ST_DUMMY;
                end
                else
                begin
                  case (dataKind)
                    `SFCRF_KIND_IN  : state <= `SFCRF_ST_DATAIN;
                    `SFCRF_KIND_OUT : state <= `SFCRF_ST_DATAOUT;
                    default         : state <= `SFCRF_ST_IGNORE;
                  endcase
                end
              end
            end
          end
          `SFCRF_ST_DUMMY:
          begin
            if (byteDone)
            begin
              byteCnt <= byteCnt + 2'h1;
              if (byteCnt + 2'h1 == dummyNeed)
              begin
                state <= `SFCRF_ST_DATAOUT;
              end
            end
          end
          `SFCRF_ST_DATAIN:
          begin
            if (byteDone)
            begin
              rxValid <= 1'b1;
              rxByte  <= fullByte;
              if (exactOne)
              begin
                state <= `SFCRF_ST_IGNORE;
              end
            end
          end
          `SFCRF_ST_DATAOUT:
          begin
            if (loadByte && idLimit)
            begin
              state <= `SFCRF_ST_IGNORE;
            end
          end
          `SFCRF_ST_IGNORE:
          begin
            state <= `SFCRF_ST_IGNORE;
          end
          default:
          begin
            state <= `SFCRF_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Read address counter and fetch credit
  // ****************************************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fetchAddr <= {ADDR_WIDTH{1'b0}};
      pending   <= 2'h0;
    end
    else
    begin
      if (cmdValid)
      begin
        fetchAddr <= cmdAddr;
      end
      else if (fetchGo)
      begin
        fetchAddr <= fetchAddr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
      end
      if (!inDataOut)
      begin
        pending <= 2'h0;
      end
      else if (fetchGo && !rdTake)
      begin
        pending <= pending + 2'h1;
      end
      else if (rdTake && !fetchGo && pending != 2'h0)
      begin
        pending <= pending - 2'h1;
      end
    end
  end

  // ****************************************************************
  // Output shifter, changes on falling edges
  // ****************************************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      so         <= 1'b0;
      outStarted <= 1'b0;
      outBit     <= 3'h0;
      outShift   <= 7'h00;
      outBytes   <= 3'h0;
    end
    else if (!inDataOut)
    begin
      outStarted <= 1'b0;
      outBit     <= 3'h0;
      outBytes   <= 3'h0;
    end
    else if (sckFall)
    begin
      outStarted <= 1'b1;
      outBit     <= outBit + 3'h1;
      if (outBit == 3'h0)
      begin
        // Empty buffer shows ones rather than stale data
        so       <= bufValid ? bufData[7] : 1'b1;
        outShift <= bufValid ? bufData[6:0] : 7'h7F;
        if (outBytes != `SFCRF_ID_MAX_BYTES)
        begin
          outBytes <= outBytes + 3'h1;
        end
      end
      else
      begin
        so       <= outShift[6];
        outShift <= {outShift[5:0], 1'b1};
      end
    end
  end

endmodule

// *** sfcrf_front_properties.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Front end checker
// ****************************************************************
module sfcrf_front_properties
#(
  parameter ADDR_WIDTH = 23
)
(
  input wire                  clk,
  input wire                  nrst,
  input wire                  csN,
  input wire                  sck,
  input wire                  holdN,
  input wire                  soOe,
  input wire                  cmdValid,
  input wire [ADDR_WIDTH-1:0] cmdAddr,
  input wire                  rxValid,
  input wire                  cmdEnd,
  input wire                  cmdDone,
  input wire                  fetchValid,
  input wire                  fetchReady,
  input wire [ADDR_WIDTH-1:0] fetchAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_valid_pulse; cmdValid |=> !cmdValid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("cmdValid too long");
  property p_rx_pulse; rxValid |=> !rxValid; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rxValid too long");
  property p_end_pulse; cmdEnd |=> !cmdEnd; endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("cmdEnd too long");
  property p_end_desel; cmdEnd |-> csN && !cmdValid; endproperty
  a_end_desel: assert property (p_end_desel) else $error("cmdEnd while selected");
  property p_load; cmdValid |-> ##[1:2] fetchAddr == cmdAddr; endproperty
  a_load: assert property (p_load) else $error("read address not loaded");
  property p_incr; fetchValid && fetchReady && !cmdValid && !$past(cmdValid) |=> fetchAddr == $past(fetchAddr) + 1'b1; endproperty
  a_incr: assert property (p_incr) else $error("read address step wrong");
  property p_desel; $rose(csN) |-> ##[1:5] !soOe; endproperty
  a_desel: assert property (p_desel) else $error("output kept after deselect");
  property p_idle; csN [*5] |-> !soOe; endproperty
  a_idle: assert property (p_idle) else $error("output driven while idle");
  property p_hold; (!holdN && !csN && !sck) [*5] |-> !soOe; endproperty
  a_hold: assert property (p_hold) else $error("output driven in pause");
  property p_done; $changed(cmdDone) |-> cmdEnd; endproperty
  a_done: assert property (p_done) else $error("cmdDone moved off frame end");
endmodule

bind sfcrf_front sfcrf_front_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_sfcrf_front_properties
  (.clk(clk), .nrst(nrst), .csN(csN), .sck(sck), .holdN(holdN), .soOe(soOe), .cmdValid(cmdValid), .cmdAddr(cmdAddr),
   .rxValid(rxValid), .cmdEnd(cmdEnd), .cmdDone(cmdDone), .fetchValid(fetchValid), .fetchReady(fetchReady),
   .fetchAddr(fetchAddr));

// *** sfcrf_host_model.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Serial host model
// ****************************************************************
module sfcrf_host_model
(
  output logic csN,
  output logic sck,
  output logic si,
  output logic holdN,
  input  wire  so,
  input  wire  soOe
);
  logic mode3;
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
    mode3 = 1'b0;
  end
  task automatic sel(input logic m3);
    mode3 = m3;
    sck = m3;
    #16 csN = 1'b0;
    #16;
  endtask
  task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      #16 sck = 1'b1;
      #15 rx[i] = soOe ? so : ~so;
      #1;
    end
  endtask
  task automatic desel();
    sck = mode3;
    #16 csN = 1'b1;
    si = ~si;
    #32;
  endtask
  task automatic hold_on();
    sck = 1'b0;
    #16 holdN = 1'b0;
  endtask
  task automatic hold_off();
    holdN = 1'b1;
    #16;
  endtask
endmodule

// *** sfcrf_front_tb_top.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Front end testbench
// ****************************************************************
module sfcrf_front_tb_top;
  localparam logic [15:0] CMDS [30] = '{16'h1B3B, 16'h0B37, 16'h0333, 16'h3B37, 16'h2030, 16'h5230, 16'hD830,
    16'h6000, 16'hC700, 16'h0231, 16'hA231, 16'hB000, 16'hD000, 16'h0600, 16'h0400, 16'h3630, 16'h3930, 16'h3C33,
    16'h3332, 16'h3432, 16'h3533, 16'h9B31, 16'h773B, 16'h0503, 16'h0102, 16'h3102, 16'hF002, 16'h9F03, 16'hB900,
    16'hAB00};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        fetchReady = 1'b0;
  logic        rdValid = 1'b0;
  logic [7:0]  rdData = 8'h00;
  wire         csN, sck, si, holdN, so, soOe, cmdValid, rxValid, cmdEnd, cmdDone, fetchValid, rdReady;
  wire  [7:0]  cmdOpcode, rxByte;
  wire  [22:0] cmdAddr, fetchAddr;
  int          seed = 85;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          nValid;
  logic        endSeen;
  logic        done;
  logic [7:0]  opc;
  logic [22:0] adr;
  logic [7:0]  rxq [$];
  logic [7:0]  txq [$];
  logic [22:0] fq [$];
  logic [31:0] rnd;

  always #2 clk = ~clk;

  sfcrf_front u_sfcrf_front (.clk(clk), .nrst(nrst), .csN(csN), .sck(sck), .si(si), .holdN(holdN), .so(so),
    .soOe(soOe), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .rxValid(rxValid), .rxByte(rxByte),
    .cmdEnd(cmdEnd), .cmdDone(cmdDone), .fetchValid(fetchValid), .fetchReady(fetchReady), .fetchAddr(fetchAddr),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
  sfcrf_host_model u_sfcrf_host_model (.csN(csN), .sck(sck), .si(si), .holdN(holdN), .so(so), .soOe(soOe));

  function automatic logic [7:0] memf(input logic [22:0] a);
    return a[7:0] ^ a[15:8] ^ a[22:15];
  endfunction

  // ****************************************************************
  // Memory responder and result monitor
  // ****************************************************************
  always @(posedge clk)
  begin
    if (cmdValid)
    begin
      nValid++;
      opc = cmdOpcode;
      adr = cmdAddr;
    end
    if (rxValid) rxq.push_back(rxByte);
    if (cmdEnd)
    begin
      endSeen = 1'b1;
      done = cmdDone;
    end
    if (rdValid && rdReady) void'(fq.pop_front());
    if (fetchValid && fetchReady) fq.push_back(fetchAddr);
    if (cmdEnd) fq.delete();
    #1;
    rnd = $random(seed);
    fetchReady = fq.size() == 0 || rnd[0];
    rdValid = fq.size() > 0;
    rdData = (fq.size() > 0) ? memf(fq[0]) : rnd[15:8];
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One frame: opcode, address, dummies, data in, data out, partial bits
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int na, nd, ni, no, part,
                     input bit ex1, kn, hld);
    logic [7:0]  r;
    logic [7:0]  tx;
    logic [22:0] fa;
    nValid = 0;
    endSeen = 1'b0;
    rxq.delete();
    txq.delete();
    fa = (na > 0) ? a[22:0] : 23'h0;
    u_sfcrf_host_model.sel(a[0] & !hld);
    u_sfcrf_host_model.bits(8, op, r);
    for (int i = 0; i < na; i++) u_sfcrf_host_model.bits(8, a[23 - 8 * i -: 8], r);
    for (int i = 0; i < nd; i++) u_sfcrf_host_model.bits(8, 8'($random(seed)), r);
    for (int i = 0; i < ni; i++)
    begin
      tx = 8'($random(seed));
      txq.push_back(tx);
      u_sfcrf_host_model.bits(8, tx, r);
    end
    for (int i = 0; i < no; i++)
    begin
      u_sfcrf_host_model.bits(8, 8'h00, r);
      chk(r, memf(fa + 23'(i)));
      if (hld && i == 0)
      begin
        u_sfcrf_host_model.hold_on();
        repeat (16) @(posedge clk);
        #1 chk(soOe, 1'b0);
        u_sfcrf_host_model.hold_off();
      end
    end
    if (part > 0) u_sfcrf_host_model.bits(part, 8'h00, r);
    u_sfcrf_host_model.desel();
    @(posedge clk);
    for (int k = 0; k < 40 && !endSeen; k++) @(posedge clk);
    if (!endSeen)
    begin
      n_mismatch++;
      print_verdict();
    end
    #1 chk(24'(nValid), kn);
    if (kn) chk(opc, op);
    if (kn) chk(adr, fa);
    chk(24'(rxq.size()), kn ? (ex1 ? 1 : ni) : 0);
    foreach (rxq[j]) chk(rxq[j], txq[j]);
    chk(done, kn && part == 0);
    chk(soOe, 1'b0);
    $display("frame %h done", op);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1 run(8'h03, 24'hFF_FFFE, 3, 0, 0, 4, 0, 0, 1, 0);
    for (int i = 0; i < 30; i++)
    begin
      rnd = $random(seed);
      run(CMDS[i][15:8], rnd[23:0], CMDS[i][7:4], CMDS[i][3:2], (CMDS[i][1:0] == 1 || CMDS[i][1:0] == 2) ? 2 : 0,
          (CMDS[i][1:0] == 3) ? 3 : 0, 0, CMDS[i][1:0] == 2, 1, i == 0);
    end
    run(8'hFF, rnd[23:0], 3, 0, 2, 0, 0, 0, 0, 0);
    run(8'h20, rnd[23:0], 2, 0, 0, 0, 0, 0, 0, 0);
    run(8'h0B, rnd[23:0], 3, 1, 0, 2, 3, 0, 1, 0);
    print_verdict();
  end

  initial
  begin
    #300000;
    n_mismatch++;
    print_verdict();
  end
endmodule
